// ### bench/testbench.sv
// Self-checking bench for the two-level interrupt controller
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CD = 4;
   localparam int LAT = 3;
   typedef struct packed { logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e; } tlip_row_t;
   tlip_row_t   rows [0:10] = '{{8'h00,1'b0,32'h0,32'h0,1'b0}, {8'h04,1'b0,32'h0,32'h0,1'b0},
      {8'h10,1'b0,32'h0,32'hff,1'b0}, {8'h14,1'b0,32'h0,32'h0,1'b0}, {8'h00,1'b1,32'h3c,32'h0,1'b0},
      {8'h00,1'b0,32'h0,32'h3c,1'b0}, {8'h1c,1'b1,32'h7,32'h0,1'b0}, {8'h1c,1'b0,32'h0,32'h7,1'b0},
      {8'h24,1'b0,32'h0,32'h0,1'b1}, {8'h20,1'b1,32'h5,32'h0,1'b1}, {8'h00,1'b1,32'h0,32'h0,1'b0}};
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [7:0]  src_event = 8'h00;
   logic        ret_req = 1'b0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, ret_pulse, vec_take, stack_push, irq;
   logic [15:0] vec_addr, pc;
   int          miscompares = 0;
   int          total_checks = 0;

   always #50 clk = ~clk;

   tlip_ctrl #(.N(8), .CLK_DIV(CD), .LAT(LAT)) u_dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_event(src_event), .return_from_irq_instr(ret_pulse), .vec_take(vec_take), .vec_addr(vec_addr),
      .stack_push(stack_push), .instr_tick(), .irq(irq));
   tlip_core_model u_core (.clk(clk), .rst(rst), .vec_take(vec_take), .stack_push(stack_push),
      .vec_addr(vec_addr), .ret_req(ret_req), .ret_pulse(ret_pulse), .pc(pc));

   task automatic end_of_test;
      $display("Checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (i == 20)
      begin
         chk("pready", 32'h1, 32'h0);
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic pulse(input logic [7:0] v);
      src_event <= v;
      @(posedge clk);
      src_event <= 8'h00;
   endtask

   task automatic ret;
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
      @(posedge clk);
   endtask

   // Waits a bounded time for a take; optionally checks event latency
   task automatic wait_take(input logic [15:0] a, input logic hit, input logic lat);
      int n;
      for (n = 1; n < 40; n++)
      begin
         @(posedge clk);
         if (vec_take === 1'b1)
            break;
      end
      chk("taken", {31'h0, hit}, {31'h0, n < 40});
      if (hit && lat)
         chk("latency", 32'h1, {31'h0, n >= CD * LAT - 1 && n <= CD * (LAT + 1) + 2});
      if (hit)
      begin
         @(posedge clk);
         chk("pc", {16'h0, a}, {16'h0, pc});
      end
   endtask

   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 11; i++)
      begin
         apb(rows[i].a, rows[i].w, rows[i].d);
         chk("refused", {31'h0, rows[i].e}, {31'h0, err});
         if (!rows[i].w)
            chk("read", rows[i].x, rd);
      end
      pulse(8'h20);
      wait_take(16'h0, 1'b0, 1'b0);
      apb(8'h08, 1'b0, 32'h0);
      chk("poll flag", 32'h20, rd);
      apb(8'h10, 1'b1, 32'h0);
      apb(8'h0c, 1'b1, 32'h11);
      apb(8'h08, 1'b1, 32'hff);
      apb(8'h00, 1'b1, 32'h80);
      pulse(8'h10);
      wait_take(16'h0, 1'b0, 1'b0);
      apb(8'h08, 1'b1, 32'h10);
      apb(8'h00, 1'b1, 32'hc0);
      pulse(8'h02);
      wait_take(16'h0, 1'b0, 1'b0);
      pulse(8'h10);
      wait_take(16'h0008, 1'b1, 1'b1);
      apb(8'h00, 1'b0, 32'h0);
      chk("ctrl after take", 32'h40, rd);
      chk("irq", 32'h1, {31'h0, irq});
      apb(8'h08, 1'b1, 32'h10);
      ret();
      apb(8'h00, 1'b0, 32'h0);
      chk("ctrl after return", 32'hc0, rd);
      apb(8'h18, 1'b1, 32'h7);
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(8'h00, 1'b1, 32'h0);
      apb(8'h04, 1'b1, 32'h80);
      apb(8'h10, 1'b1, 32'h01);
      apb(8'h08, 1'b1, 32'hff);
      apb(8'h0c, 1'b1, 32'h03);
      apb(8'h00, 1'b1, 32'hc0);
      pulse(8'h03);
      wait_take(16'h0008, 1'b1, 1'b1);
      apb(8'h00, 1'b0, 32'h0);
      chk("ctrl high taken", 32'h40, rd);
      wait_take(16'h0, 1'b0, 1'b0);
      apb(8'h08, 1'b1, 32'h01);
      ret();
      wait_take(16'h0018, 1'b1, 1'b0);
      apb(8'h00, 1'b0, 32'h0);
      chk("ctrl low taken", 32'h80, rd);
      pulse(8'h01);
      wait_take(16'h0008, 1'b1, 1'b1);
      apb(8'h18, 1'b0, 32'h0);
      chk("preempt status", 32'h1, {31'h0, rd[2]});
      chk("irq status", 32'h7, rd);
      apb(8'h14, 1'b0, 32'h0);
      chk("state nested", 32'h0008_0003, rd);
      apb(8'h1c, 1'b1, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(8'h1c, 1'b1, 32'h7);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      // Reset in mid-run: everything back to compatibility mode
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("vec_addr after reset", 32'h0, {16'h0, vec_addr});
      chk("irq after reset", 32'h0, {31'h0, irq});
      apb(8'h04, 1'b0, 32'h0);
      chk("prio enable after reset", 32'h0, rd);
      apb(8'h14, 1'b0, 32'h0);
      chk("state after reset", 32'h0, rd);
      end_of_test();
   end
endmodule // testbench

// ### bench/tlip_checker.sv
// Port-level assertions for the interrupt controller
module tlip_checker (
   input wire        clk,
   input wire        rst,
   input wire [7:0]  paddr,
   input wire        psel,
   input wire        penable,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        vec_take,
   input wire [15:0] vec_addr,
   input wire        stack_push,
   input wire        instr_tick,
   input wire        irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_push_with_take: assert property (vec_take |-> stack_push && !$past(vec_take))
      else $error("vector taken without a stack push");
   a_vec_addr_legal: assert property (vec_take |-> vec_addr == 16'h0008 || vec_addr == 16'h0018)
      else $error("vector address outside the two vectors");
   a_vec_addr_hold: assert property ($changed(vec_addr) |-> vec_take)
      else $error("vector address moved without a take");
   a_take_on_tick: assert property (vec_take |-> $past(instr_tick))
      else $error("vector taken off the instruction boundary");
   a_tick_period: assert property (instr_tick |=> !instr_tick [*3] ##1 instr_tick)
      else $error("instruction tick period wrong");
   a_take_spacing: assert property (vec_take |=> !vec_take [*3])
      else $error("two takes too close");
   a_reset_quiet: assert property ($fell(rst) |-> !vec_take && !irq && vec_addr == 16'h0000)
      else $error("outputs not quiet after reset");
   a_unmapped_err: assert property (psel && penable && paddr > 8'h1c |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (psel && penable && paddr <= 8'h1c && paddr[1:0] == 2'b00 |-> pready && !pslverr)
      else $error("mapped access refused");

   c_high_take: cover property (vec_take && vec_addr == 16'h0008);
   c_low_take: cover property (vec_take && vec_addr == 16'h0018);
   c_refused: cover property (pslverr);
   c_irq: cover property (irq);
endmodule // tlip_checker

bind tlip_ctrl tlip_checker u_chk (
   .clk        (clk),
   .rst        (rst),
   .paddr      (paddr),
   .psel       (psel),
   .penable    (penable),
   .prdata     (prdata),
   .pready     (pready),
   .pslverr    (pslverr),
   .vec_take   (vec_take),
   .vec_addr   (vec_addr),
   .stack_push (stack_push),
   .instr_tick (instr_tick),
   .irq        (irq)
);

// ### bench/tlip_core_model.sv
// Core model: program counter, return stack and return pulse
module tlip_core_model (
   input  wire        clk,
   input  wire        rst,
   input  wire        vec_take,
   input  wire        stack_push,
   input  wire [15:0] vec_addr,
   input  wire        ret_req,
   output reg         ret_pulse,
   output reg  [15:0] pc
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [15:0] stk [0:15];
   reg [3:0]  depth;
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         depth <= 4'h0;
         pc <= 16'h0100;
         ret_pulse <= 1'b0;
      end
      else
      begin
         ret_pulse <= ret_req && depth != 4'h0;
         if (vec_take && stack_push)
         begin
            stk[depth] <= pc;
            depth <= depth + 4'h1;
            pc <= vec_addr;
         end
         else if (ret_req && depth != 4'h0)
         begin
            depth <= depth - 4'h1;
            pc <= stk[depth - 4'h1];
         end
      end
   end
endmodule // tlip_core_model

// ### common/tlip_regs.vh
// Register map, field positions, vectors and timing counts of the interrupt controller
`ifndef TLIP_REGS_VH
`define TLIP_REGS_VH

// Register byte offsets
`define TLIP_OFS_CTRL      8'h00
`define TLIP_OFS_RSTCTL    8'h04
`define TLIP_OFS_FLAG      8'h08
`define TLIP_OFS_ENABLE    8'h0c
`define TLIP_OFS_PRIO      8'h10
`define TLIP_OFS_STATE     8'h14
`define TLIP_OFS_IRQ_STAT  8'h18
`define TLIP_OFS_IRQ_MASK  8'h1c

// irq_control_reg fields
`define TLIP_BIT_HIGH_EN   7
`define TLIP_BIT_LOW_EN    6
// reset_control_reg field
`define TLIP_BIT_PRIO_EN   7

// State register fields
`define TLIP_BIT_IN_HIGH   0
`define TLIP_BIT_IN_LOW    1
`define TLIP_BIT_BUSY      2
`define TLIP_VEC_LSB       16

// Interrupt status fields
`define TLIP_IST_TAKE      0
`define TLIP_IST_RETURN    1
`define TLIP_IST_PREEMPT   2
`define TLIP_IST_W         3

// Vector addresses
`define TLIP_VEC_HIGH      16'h0008
`define TLIP_VEC_LOW       16'h0018

// Reset values
`define TLIP_RST_CTRL      8'h00
`define TLIP_RST_RSTCTL    8'h00
`define TLIP_RST_IST       3'h0
`define TLIP_RST_VEC       16'h0000

// Timing: clocks per instruction cycle, instruction cycles of wait before vectoring
`define TLIP_CLK_PER_INSTR 4
`define TLIP_LAT_INSTR     3

`endif

// ### hw/tlip_arb.v
// Request qualification and level selection for the two-level interrupt controller
module tlip_arb #(
   parameter N = 8
) (
   input  wire [N-1:0] flag,
   input  wire [N-1:0] enable,
   input  wire [N-1:0] prio,
   input  wire [N-1:0] periph,
   input  wire         prio_mode,
   input  wire         high_en,
   input  wire         low_en,
   input  wire         in_high,
   output wire         req_high,
   output wire         req_low
);

   wire [N-1:0] armed;
   wire [N-1:0] compat_ok;
   wire         any_high;
   wire         any_low;
   wire         any_compat;

   // Flag, individual enable and group enable all needed
   assign armed      = flag & enable;
   assign any_high   = |(armed & prio);
   assign any_low    = |(armed & ~prio);
   // Compatibility: priority ignored, peripherals gated by bit 6
   assign compat_ok  = ~periph | {N{low_en}};
   assign any_compat = |(armed & compat_ok);

   assign req_high = prio_mode ? (any_high & high_en)
                               : (any_compat & high_en);
   // Low level held off while a high routine runs
   assign req_low  = prio_mode & any_low & low_en & ~in_high;

endmodule // tlip_arb

// ### hw/tlip_ctrl.v
// Two-level interrupt priority controller with APB registers and core vector port
//
// How it works
// - High level vectors 0008h, low level 0018h.
// - Pending high request preempts running low routine.
// - Priority levels only while priority enable set.
// - Priority enable resets cleared: compatibility mode.
// - Bit 7 gates high sources, bit 6 low.
// - Vector needs flag, enable and group enable.
// - Compatibility mode ignores priority, vectors 0008h.
// - Compatibility: bit 6 peripherals, bit 7 all.
// - Entry clears the governing global or group enable.
// - Low requests wait while high routine runs.
// - Entry pushes return address, loads vector into PC.
// - Return instruction exits and sets matching enable.
// - Event to vector takes three to four instructions.
// - Latency independent of one or two cycle instructions.
// - Flags set on events whatever the enables.
// - Each source has flag, enable, priority bit.
`include "tlip_regs.vh"

module tlip_ctrl #(
   parameter         N          = 8,
   parameter [31:0]  PERIPH_MAP = 32'hffff_fff0,
   parameter [31:0]  PRIO_RST   = 32'hffff_ffff,
   parameter         CLK_DIV    = `TLIP_CLK_PER_INSTR,
   parameter         LAT        = `TLIP_LAT_INSTR
) (
   input  wire         clk,
   input  wire         rst,
   input  wire [7:0]   paddr,
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output wire         pready,
   output reg          pslverr,
   input  wire [N-1:0] src_event,
   input  wire         return_from_irq_instr,
   output reg          vec_take,
   output reg  [15:0]  vec_addr,
   output reg          stack_push,
   output wire         instr_tick,
   output wire         irq
);

   localparam S_IDLE = 2'b01;
   localparam S_WAIT = 2'b10;

   reg  [7:0]             ctrl_reg;
   reg  [7:0]             rstctl_reg;
   reg  [N-1:0]           flag_reg;
   reg  [N-1:0]           en_reg;
   reg  [N-1:0]           prio_reg;
   reg  [`TLIP_IST_W-1:0] ist_reg;
   reg  [`TLIP_IST_W-1:0] imask_reg;
   reg  [1:0]             state_reg;
   reg  [1:0]             state_next;
   reg  [7:0]             div_reg;
   reg  [7:0]             lat_reg;
   reg                    in_high_reg;
   reg                    in_low_reg;
   reg  [15:0]            last_vec_reg;

   wire        prio_mode;
   wire        high_en;
   wire        low_en;
   wire        req_high;
   wire        req_low;
   wire        setup;
   wire        wr;
   wire        take_now;
   wire        take_high;
   wire        take_low;
   wire        do_ret;
   wire        preempt;
   wire [N-1:0] periph;

   reg  [N-1:0]           flag_next;
   reg  [7:0]             ctrl_next;
   reg  [`TLIP_IST_W-1:0] ist_next;
   reg  [`TLIP_IST_W-1:0] ist_set;
   reg                    in_high_next;
   reg                    in_low_next;

   function [N-1:0] wsel;
      input [31:0] d;
      begin
         wsel = d[N-1:0];
      end
   endfunction

   function [31:0] zext;
      input [N-1:0] d;
      begin
         zext = 32'h0000_0000;
         zext[N-1:0] = d;
      end
   endfunction

   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   assign periph    = PERIPH_MAP[N-1:0];
   assign prio_mode = rstctl_reg[`TLIP_BIT_PRIO_EN];
   assign high_en   = ctrl_reg[`TLIP_BIT_HIGH_EN];
   assign low_en    = ctrl_reg[`TLIP_BIT_LOW_EN];
   assign setup     = psel & ~penable;
   assign wr        = psel & penable & pwrite;
   assign pready    = 1'b1;
   assign irq       = |(ist_reg & imask_reg);

   // Instruction cycle enable from the core clock
   assign instr_tick = (div_reg == CLK_DIV - 1);

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         div_reg <= 8'h00;
      else if (instr_tick)
         div_reg <= 8'h00;
      else
         div_reg <= div_reg + 8'h01;
   end

   tlip_arb #(
      .N (N)
   ) u_arb (
      .flag      (flag_reg),
      .enable    (en_reg),
      .prio      (prio_reg),
      .periph    (periph),
      .prio_mode (prio_mode),
      .high_en   (high_en),
      .low_en    (low_en),
      .in_high   (in_high_reg),
      .req_high  (req_high),
      .req_low   (req_low)
   );

   // Vector fires when the wait ends on an instruction boundary
   assign take_now  = (state_reg == S_WAIT) & instr_tick & (lat_reg == LAT - 1);
   assign take_high = take_now & req_high;
   assign take_low  = take_now & ~req_high & req_low;
   assign preempt   = take_high & prio_mode & in_low_reg;
   assign do_ret    = return_from_irq_instr;

   // Wait counts whole instruction cycles, never instruction length
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE:
         begin
            if (instr_tick & (req_high | req_low))
               state_next = S_WAIT;
         end
         S_WAIT:
         begin
            if (instr_tick & ~(req_high | req_low))
               state_next = S_IDLE;
            else if (take_now)
               state_next = S_IDLE;
         end
         default:
            state_next = S_IDLE;
      endcase
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= S_IDLE;
         lat_reg   <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg != S_WAIT)
            lat_reg <= 8'h00;
         else if (instr_tick)
            lat_reg <= lat_reg + 8'h01;
      end
   end

   // Core port: vector and push strobe
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         vec_take     <= 1'b0;
         stack_push   <= 1'b0;
         vec_addr     <= `TLIP_RST_VEC;
         last_vec_reg <= `TLIP_RST_VEC;
      end
      else
      begin
         vec_take   <= take_high | take_low;
         stack_push <= take_high | take_low;
         if (take_high)
         begin
            vec_addr     <= `TLIP_VEC_HIGH;
            last_vec_reg <= `TLIP_VEC_HIGH;
         end
         else if (take_low)
         begin
            vec_addr     <= `TLIP_VEC_LOW;
            last_vec_reg <= `TLIP_VEC_LOW;
         end
      end
   end

   // Enables and service tracking
   always @*
   begin
      ctrl_next    = ctrl_reg;
      in_high_next = in_high_reg;
      in_low_next  = in_low_reg;
      if (wr & hit(paddr, `TLIP_OFS_CTRL))
         ctrl_next = pwdata[7:0];
      if (do_ret)
      begin
         if (~prio_mode)
         begin
            ctrl_next[`TLIP_BIT_HIGH_EN] = 1'b1;
            in_high_next = 1'b0;
            in_low_next  = 1'b0;
         end
         else if (in_high_reg)
         begin
            ctrl_next[`TLIP_BIT_HIGH_EN] = 1'b1;
            in_high_next = 1'b0;
         end
         else
         begin
            ctrl_next[`TLIP_BIT_LOW_EN] = 1'b1;
            in_low_next = 1'b0;
         end
      end
      // Entry beats a software write in the same cycle
      if (take_high)
      begin
         ctrl_next[`TLIP_BIT_HIGH_EN] = 1'b0;
         in_high_next = 1'b1;
      end
      else if (take_low)
      begin
         ctrl_next[`TLIP_BIT_LOW_EN] = 1'b0;
         in_low_next = 1'b1;
      end
   end

   // Flags: event set wins over write-one-to-clear
   always @*
   begin
      flag_next = flag_reg;
      if (wr & hit(paddr, `TLIP_OFS_FLAG))
         flag_next = flag_reg & ~wsel(pwdata);
      flag_next = flag_next | src_event;
   end

   always @*
   begin
      ist_set = {`TLIP_IST_W{1'b0}};
      ist_set[`TLIP_IST_TAKE]    = take_high | take_low;
      ist_set[`TLIP_IST_RETURN]  = do_ret;
      ist_set[`TLIP_IST_PREEMPT] = preempt;
      ist_next = ist_reg;
      if (wr & hit(paddr, `TLIP_OFS_IRQ_STAT))
         ist_next = ist_reg & ~pwdata[`TLIP_IST_W-1:0];
      ist_next = ist_next | ist_set;
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_reg    <= `TLIP_RST_CTRL;
         rstctl_reg  <= `TLIP_RST_RSTCTL;
         flag_reg    <= {N{1'b0}};
         en_reg      <= {N{1'b0}};
         prio_reg    <= PRIO_RST[N-1:0];
         ist_reg     <= `TLIP_RST_IST;
         imask_reg   <= `TLIP_RST_IST;
         in_high_reg <= 1'b0;
         in_low_reg  <= 1'b0;
      end
      else
      begin
         ctrl_reg    <= ctrl_next;
         flag_reg    <= flag_next;
         ist_reg     <= ist_next;
         in_high_reg <= in_high_next;
         in_low_reg  <= in_low_next;
         if (wr & hit(paddr, `TLIP_OFS_RSTCTL))
            rstctl_reg <= pwdata[7:0] & (8'h01 << `TLIP_BIT_PRIO_EN);
         if (wr & hit(paddr, `TLIP_OFS_ENABLE))
            en_reg <= wsel(pwdata);
         if (wr & hit(paddr, `TLIP_OFS_PRIO))
            prio_reg <= wsel(pwdata);
         if (wr & hit(paddr, `TLIP_OFS_IRQ_MASK))
            imask_reg <= pwdata[`TLIP_IST_W-1:0];
      end
   end

   // Read data captured in the setup cycle, shown in the access cycle
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         case (paddr)
            `TLIP_OFS_CTRL:     prdata[7:0] <= ctrl_reg;
            `TLIP_OFS_RSTCTL:   prdata[7:0] <= rstctl_reg;
            `TLIP_OFS_FLAG:     prdata <= zext(flag_reg);
            `TLIP_OFS_ENABLE:   prdata <= zext(en_reg);
            `TLIP_OFS_PRIO:     prdata <= zext(prio_reg);
            `TLIP_OFS_STATE:
            begin
               prdata[`TLIP_BIT_IN_HIGH] <= in_high_reg;
               prdata[`TLIP_BIT_IN_LOW]  <= in_low_reg;
               prdata[`TLIP_BIT_BUSY]    <= (state_reg == S_WAIT);
               prdata[31:`TLIP_VEC_LSB]  <= last_vec_reg;
            end
            `TLIP_OFS_IRQ_STAT: prdata[`TLIP_IST_W-1:0] <= ist_reg;
            `TLIP_OFS_IRQ_MASK: prdata[`TLIP_IST_W-1:0] <= imask_reg;
            default:            pslverr <= 1'b1;
         endcase
      end
   end

endmodule // tlip_ctrl
